// file: design/tcb_pkg.sv
// Register map, field positions, mode codes and reset values of the trace compare block.
package tcb_pkg;

  // ==========================================================================
  // Register offsets
  localparam int             REG_AW          = 5;
  localparam logic [4:0]     OFS_CTRL        = 5'h00;
  localparam logic [4:0]     OFS_CMP_FIRST   = 5'h01;
  localparam logic [4:0]     OFS_CMP_LAST    = 5'h09;
  localparam logic [4:0]     OFS_RWSEL       = 5'h0A;
  localparam logic [4:0]     OFS_TRIG        = 5'h0D;
  localparam logic [4:0]     OFS_STATUS      = 5'h0E;
  localparam logic [4:0]     OFS_COUNT       = 5'h0F;
  localparam logic [4:0]     OFS_FIFO_EXT    = 5'h10;
  localparam logic [4:0]     OFS_FIFO_HIGH   = 5'h11;
  localparam logic [4:0]     OFS_FIFO_LOW    = 5'h12;

  // ==========================================================================
  // Comparator register indices (extended, high, low for A, B and C)
  localparam int             CMP_NUM         = 9;
  localparam int             CMP_A_EXT       = 0;
  localparam int             CMP_A_HIGH      = 1;
  localparam int             CMP_A_LOW       = 2;
  localparam int             CMP_B_EXT       = 3;
  localparam int             CMP_B_HIGH      = 4;
  localparam int             CMP_B_LOW       = 5;
  localparam int             CMP_C_EXT       = 6;
  localparam int             CMP_C_HIGH      = 7;
  localparam int             CMP_C_LOW       = 8;
  localparam int             PAGE_SEL_BIT    = 7;

  // ==========================================================================
  // Field positions
  localparam int             CTRL_EN_BIT     = 7;
  localparam int             CTRL_ARM_BIT    = 6;
  localparam int             CTRL_TAG_BIT    = 5;
  localparam int             CTRL_BRK_BIT    = 4;
  localparam int             CTRL_LOOP_BIT   = 0;
  localparam logic [7:0]     CTRL_MASK       = 8'hF1;
  localparam logic [7:0]     CTRL_RUN_CLR    = 8'h50;
  localparam int             RW_A_EN_BIT     = 3;
  localparam int             RW_A_SEL_BIT    = 2;
  localparam int             RW_B_EN_BIT     = 1;
  localparam int             RW_B_SEL_BIT    = 0;
  localparam logic [7:0]     RW_MASK         = 8'h0F;
  localparam int             TRIG_QUAL_BIT   = 7;
  localparam int             TRIG_BEGIN_BIT  = 6;
  localparam logic [7:0]     TRIG_MASK       = 8'hCF;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]     CTRL_RST        = 8'h00;
  localparam logic [7:0]     RW_RST          = 8'h00;
  localparam logic [7:0]     TRIG_RST        = 8'h40;
  localparam logic [7:0]     CMP_RST         = 8'h00;

  // ==========================================================================
  // Trigger mode codes
  localparam logic [3:0]     MODE_A_ONLY     = 4'h0;
  localparam logic [3:0]     MODE_A_OR_B     = 4'h1;
  localparam logic [3:0]     MODE_A_THEN_B   = 4'h2;
  localparam logic [3:0]     MODE_EV_B       = 4'h3;
  localparam logic [3:0]     MODE_A_THEN_EVB = 4'h4;
  localparam logic [3:0]     MODE_A_AND_B    = 4'h5;
  localparam logic [3:0]     MODE_A_NOT_B    = 4'h6;
  localparam logic [3:0]     MODE_INSIDE     = 4'h7;
  localparam logic [3:0]     MODE_OUTSIDE    = 4'h8;

  // ==========================================================================
  // Trace buffer
  localparam int             FIFO_DEPTH      = 8;
  localparam int             PTR_W           = 3;
  localparam int             WORD_W          = 18;
  localparam int             ADDR_W          = 17;
  localparam logic [3:0]     CNT_FULL        = 4'h8;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_FILL} tcb_state_e;

endpackage

// file: design/tcb_top.sv
// Trace valid count, comparators, loop suppression, trigger and breakpoint logic.
module tcb_top
  import tcb_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        sysRst,
  input  wire logic [tcb_pkg::REG_AW-1:0]  regAddr,
  input  wire logic [7:0]                  regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [7:0]                  regRdData,
  input  wire logic                        busValid,
  input  wire logic [tcb_pkg::ADDR_W-1:0]  busAddr,
  input  wire logic                        busRead,
  input  wire logic [7:0]                  busRdData,
  input  wire logic [7:0]                  busWrData,
  input  wire logic                        cofValid,
  input  wire logic [tcb_pkg::ADDR_W-1:0]  cofAddr,
  input  wire logic                        cofPaged,
  input  wire logic                        opExecValid,
  input  wire logic [tcb_pkg::ADDR_W-1:0]  opExecAddr,
  output logic                             forceBreak,
  output logic                             tagBreak
);
  import tcb_pkg::*;

  // ==========================================================================
  // State
  logic [7:0]         ctrlR;
  logic [7:0]         rwR;
  logic [7:0]         trigR;
  logic [7:0]         cmpR [CMP_NUM];
  logic [3:0]         cntR;
  logic [3:0]         cnt_nxt;
  logic               afR;
  logic               bfR;
  logic               cfR;
  logic               seenAR;
  logic [WORD_W-1:0]  fifoMem [FIFO_DEPTH];
  logic [PTR_W-1:0]   wrPtrR;
  logic [PTR_W-1:0]   wrPtr_nxt;
  logic [PTR_W-1:0]   rdPtrR;
  tcb_state_e         stateR;

  // ==========================================================================
  // Decoded controls
  logic               modEn;
  logic               armedRun;
  logic               armSet;
  logic               keepRun;
  logic [3:0]         mode;
  logic               eventOnly;
  logic               fullMode;
  logic               beginEff;
  logic               qualOn;
  logic               loopOn;
  logic [ADDR_W-1:0]  addrA;
  logic [ADDR_W-1:0]  addrB;
  logic [ADDR_W-1:0]  addrC;
  logic               fullWrSel;
  logic               rawA;
  logic               rawB;
  logic               rawC;
  logic               hitA;
  logic               hitB;
  logic               trig;
  logic               setA;
  logic               setB;
  logic               capWin;
  logic               capReq;
  logic               dupCof;
  logic               capWr;
  logic [WORD_W-1:0]  capWord;
  logic [7:0]         dataByte;
  logic               runDone;
  logic               brkReq;
  logic               fifoPop;

  assign modEn    = ctrlR[CTRL_EN_BIT];
  assign armedRun = modEn && ctrlR[CTRL_ARM_BIT];
  assign armSet   = regWr && regAddr == OFS_CTRL && regWrData[CTRL_EN_BIT]
                    && regWrData[CTRL_ARM_BIT] && !armedRun;
  assign keepRun  = modEn && ctrlR[CTRL_ARM_BIT] && !trigR[TRIG_BEGIN_BIT];
  assign mode      = trigR[3:0];
  assign eventOnly = mode == MODE_EV_B || mode == MODE_A_THEN_EVB;
  assign fullMode  = mode == MODE_A_AND_B || mode == MODE_A_NOT_B;
  assign beginEff  = trigR[TRIG_BEGIN_BIT] || eventOnly;
  assign qualOn    = trigR[TRIG_QUAL_BIT] && !eventOnly;
  assign loopOn    = ctrlR[CTRL_LOOP_BIT] && !eventOnly;

  assign addrA = {cmpR[CMP_A_EXT][0], cmpR[CMP_A_HIGH], cmpR[CMP_A_LOW]};
  assign addrB = {cmpR[CMP_B_EXT][0], cmpR[CMP_B_HIGH], cmpR[CMP_B_LOW]};
  assign addrC = {cmpR[CMP_C_EXT][0], cmpR[CMP_C_HIGH], cmpR[CMP_C_LOW]};

  // ==========================================================================
  // Comparators
  // full direction select
  assign fullWrSel = rwR[RW_A_EN_BIT] && !rwR[RW_A_SEL_BIT];

  always_comb
  begin
    rawA = busValid && busAddr == addrA;
    rawC = busValid && busAddr == addrC;
    if (fullMode)
    begin
      rawA = rawA && (fullWrSel ? !busRead : busRead);
      rawB = busValid && (fullWrSel ? (!busRead && busWrData == cmpR[CMP_B_LOW])
                                    : (busRead && busRdData == cmpR[CMP_B_LOW]));
    end
    else
    begin
      rawA = rawA && (!rwR[RW_A_EN_BIT] || rwR[RW_A_SEL_BIT] == busRead);
      rawB = busValid && busAddr == addrB
             && (!rwR[RW_B_EN_BIT] || rwR[RW_B_SEL_BIT] == busRead);
    end
  end

  // opcode qualification
  // The data half of a full mode has no opcode address, so B stays unqualified there.
  assign hitA = qualOn ? (opExecValid && opExecAddr == addrA) : rawA;
  assign hitB = (qualOn && !fullMode) ? (opExecValid && opExecAddr == addrB) : rawB;

  // ==========================================================================
  // Trigger decision
  always_comb
  begin
    trig = 1'b0;
    setA = 1'b0;
    setB = 1'b0;
    unique case (mode)
      MODE_A_ONLY:
      begin
        trig = hitA;
        setA = hitA;
      end
      MODE_A_OR_B:
      begin
        trig = hitA || hitB;
        setA = hitA;
        setB = hitB;
      end
      MODE_A_THEN_B, MODE_A_THEN_EVB:
      begin
        trig = seenAR && hitB;
        setA = hitA;
        setB = seenAR && hitB;
      end
      MODE_EV_B:
      begin
        trig = hitB;
        setB = hitB;
      end
      MODE_A_AND_B:
      begin
        trig = hitA && hitB;
        setA = trig;
        setB = trig;
      end
      MODE_A_NOT_B:
      begin
        trig = hitA && !hitB;
        setA = trig;
        setB = trig;
      end
      MODE_INSIDE:
      begin
        trig = busValid && busAddr >= addrA && busAddr <= addrB;
        setA = trig;
        setB = trig;
      end
      MODE_OUTSIDE:
      begin
        setA = busValid && busAddr < addrA;
        setB = busValid && busAddr > addrB;
        trig = setA || setB;
      end
      default:
      begin
        trig = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Capture path
  assign dataByte = busRead ? busRdData : busWrData;
  assign capWord  = eventOnly ? {{(WORD_W-8){1'b0}}, dataByte} : {cofPaged, cofAddr};
  assign capWin   = armedRun && (!beginEff || stateR == ST_FILL || trig);
  assign capReq   = capWin && (eventOnly ? hitB : cofValid);
  assign dupCof   = loopOn && {cmpR[CMP_C_EXT][PAGE_SEL_BIT], addrC} == {cofPaged, cofAddr};
  assign capWr    = capReq && !dupCof;
  assign runDone  = armedRun && (beginEff ? (capWr && cntR == CNT_FULL - 4'h1) : trig);

  // ==========================================================================
  // Breakpoint requests
  // begin break at full
  assign brkReq = ctrlR[CTRL_BRK_BIT] && (runDone || (modEn && !loopOn && rawC));
  assign forceBreak = brkReq && !ctrlR[CTRL_TAG_BIT];
  assign tagBreak   = brkReq && ctrlR[CTRL_TAG_BIT];

  // ==========================================================================
  // Control, direction and trigger registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrlR <= CTRL_RST;
    else if (sysRst)
      ctrlR <= keepRun ? (ctrlR & ~CTRL_RUN_CLR) : CTRL_RST;
    else if (regWr && regAddr == OFS_CTRL)
      ctrlR <= regWrData & CTRL_MASK;
    else if (runDone || !modEn)
      ctrlR[CTRL_ARM_BIT] <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rwR <= RW_RST;
    else if (sysRst && !keepRun)
      rwR <= RW_RST;
    else if (regWr && regAddr == OFS_RWSEL)
      rwR <= regWrData & RW_MASK;
  end

  // The trigger register is frozen while armed; the direction and comparator registers stay writable during a run.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      trigR <= TRIG_RST;
    else if (sysRst && !keepRun)
      trigR <= TRIG_RST;
    else if (regWr && regAddr == OFS_TRIG && !ctrlR[CTRL_ARM_BIT])
      trigR <= regWrData & TRIG_MASK;
  end

  // ==========================================================================
  // Comparator value registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < CMP_NUM; i++)
        cmpR[i] <= CMP_RST;
    end
    else if (sysRst && !keepRun)
    begin
      for (int i = 0; i < CMP_NUM; i++)
        cmpR[i] <= CMP_RST;
    end
    else if (armSet && regWrData[CTRL_LOOP_BIT])
    begin
      cmpR[CMP_C_EXT]  <= CMP_RST;
      cmpR[CMP_C_HIGH] <= CMP_RST;
      cmpR[CMP_C_LOW]  <= CMP_RST;
    end
    else if (capWr && loopOn)
    begin
      cmpR[CMP_C_EXT]  <= {cofPaged, 6'h00, cofAddr[16]};
      cmpR[CMP_C_HIGH] <= cofAddr[15:8];
      cmpR[CMP_C_LOW]  <= cofAddr[7:0];
    end
    else if (regWr && regAddr >= OFS_CMP_FIRST && regAddr <= OFS_CMP_LAST)
      cmpR[4'(regAddr - OFS_CMP_FIRST)] <= regWrData;
  end

  // ==========================================================================
  // Valid count
  always_comb
  begin
    cnt_nxt = cntR;
    if (armSet)
      cnt_nxt = 4'h0;
    else if (capWr && cntR != CNT_FULL)
      cnt_nxt = cntR + 4'h1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cntR <= 4'h0;
    else if (sysRst)
      cntR <= keepRun ? cntR : 4'h0;
    else
      cntR <= cnt_nxt;
  end

  // ==========================================================================
  // Match flags and sequencing; the clear from arming wins over a new match.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      afR <= 1'b0;
      bfR <= 1'b0;
      cfR <= 1'b0;
    end
    else if (sysRst && !keepRun)
    begin
      afR <= 1'b0;
      bfR <= 1'b0;
      cfR <= 1'b0;
    end
    else
    begin
      afR <= (afR && !armSet) || (armedRun && setA);
      bfR <= (bfR && !armSet) || (armedRun && setB);
      cfR <= (cfR && !armSet) || (armedRun && rawC);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      seenAR <= 1'b0;
    else if (armSet || !armedRun)
      seenAR <= 1'b0;
    else if (hitA)
      seenAR <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      stateR <= ST_IDLE;
    else
    begin
      unique case (stateR)
        ST_IDLE:  stateR <= armSet ? ST_ARMED : ST_IDLE;
        ST_ARMED:
        begin
          if (!armedRun || sysRst || runDone)
            stateR <= ST_IDLE;
          else if (beginEff && trig)
            stateR <= ST_FILL;
        end
        ST_FILL:  stateR <= (!armedRun || sysRst || runDone) ? ST_IDLE : ST_FILL;
      endcase
    end
  end

  // ==========================================================================
  // Trace buffer; an end-type run simply wraps, dropping the oldest word.
  assign wrPtr_nxt = armSet ? '0 : (capWr ? wrPtrR + 1'b1 : wrPtrR);
  assign fifoPop   = regRd && regAddr == OFS_FIFO_LOW;

  always_ff @(posedge ref_clk)
  begin
    if (capWr)
      fifoMem[wrPtrR] <= capWord;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      wrPtrR <= '0;
    else
      wrPtrR <= wrPtr_nxt;
  end

  // Read-out starts at the oldest valid word once runDone ends a run; the count is never touched by it.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdPtrR <= '0;
    else if (runDone)
      rdPtrR <= (cnt_nxt == CNT_FULL) ? wrPtr_nxt : '0;
    else if (fifoPop)
      rdPtrR <= rdPtrR + 1'b1;
  end

  // ==========================================================================
  // Register read port
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdData <= 8'h00;
    else if (regRd)
    begin
      if (regAddr >= OFS_CMP_FIRST && regAddr <= OFS_CMP_LAST)
        regRdData <= cmpR[4'(regAddr - OFS_CMP_FIRST)];
      else
      begin
        unique case (regAddr)
          OFS_CTRL:      regRdData <= ctrlR;
          OFS_RWSEL:     regRdData <= rwR;
          OFS_TRIG:      regRdData <= trigR;
          OFS_STATUS:    regRdData <= {afR, bfR, cfR, 4'h0, armedRun};
          OFS_COUNT:     regRdData <= {4'h0, cntR};
          OFS_FIFO_EXT:  regRdData <= {fifoMem[rdPtrR][17], 6'h00, fifoMem[rdPtrR][16]};
          OFS_FIFO_HIGH: regRdData <= fifoMem[rdPtrR][15:8];
          OFS_FIFO_LOW:  regRdData <= fifoMem[rdPtrR][7:0];
          default:       regRdData <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  a_count_bound: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cntR <= CNT_FULL) else $error("Valid count above eight.");

  a_count_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
    capWr && !sysRst && cntR < CNT_FULL |=> cntR == $past(cntR) + 4'h1)
    else $error("Count did not advance on capture.");

  a_count_arm: assert property (@(posedge ref_clk) disable iff (!arst_n)
    armSet && !sysRst |=> cntR == 4'h0) else $error("Arming left count nonzero.");

  a_count_pop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fifoPop && !capWr && !armSet && !sysRst |=> $stable(cntR))
    else $error("Read-out changed the count.");

  a_count_upper: assert property (@(posedge ref_clk) disable iff (!arst_n)
    regRd && regAddr == OFS_COUNT |=> regRdData[7:4] == 4'h0 && regRdData[3:0] == $past(cntR))
    else $error("Count register read wrong.");

  a_endrun_keep: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sysRst && keepRun |=> $stable(cntR) && !ctrlR[CTRL_ARM_BIT])
    else $error("End-run reset lost the count.");

  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !modEn |-> !capWr && !runDone) else $error("Capture while disabled.");

  a_loop_discard: assert property (@(posedge ref_clk) disable iff (!arst_n)
    capReq && dupCof |-> !capWr ##1 (cntR == $past(cntR) || $past(armSet || sysRst)))
    else $error("Duplicate change-of-flow stored.");

  a_loop_loadc: assert property (@(posedge ref_clk) disable iff (!arst_n)
    capWr && loopOn && !sysRst |=> cmpR[CMP_C_EXT][PAGE_SEL_BIT] == $past(cofPaged)
    && addrC == $past(cofAddr)) else $error("Comparator C not loaded.");

  a_loop_nobrk: assert property (@(posedge ref_clk) disable iff (!arst_n)
    loopOn && rawC && !runDone |-> !forceBreak && !tagBreak)
    else $error("Comparator C broke in loop mode.");

  a_begin_full: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (forceBreak || tagBreak) && beginEff && !rawC |-> cnt_nxt == CNT_FULL)
    else $error("Begin break before buffer full.");

  a_end_break: assert property (@(posedge ref_clk) disable iff (!arst_n)
    armedRun && !beginEff && trig && ctrlR[CTRL_BRK_BIT] |-> forceBreak || tagBreak)
    else $error("End trigger without break.");

  a_brk_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !ctrlR[CTRL_BRK_BIT] |-> !forceBreak && !tagBreak)
    else $error("Break raised while disabled.");

endmodule

// file: sim/tcb_core_model.sv
// Core-side model: bus cycles, change-of-flow events and opcode execution reports.
module tcb_core_model
  import tcb_pkg::*;
(
  input  wire logic                  ref_clk,
  output logic                       busValid,
  output logic [tcb_pkg::ADDR_W-1:0] busAddr,
  output logic                       busRead,
  output logic [7:0]                 busRdData,
  output logic [7:0]                 busWrData,
  output logic                       cofValid,
  output logic [tcb_pkg::ADDR_W-1:0] cofAddr,
  output logic                       cofPaged,
  output logic                       opExecValid,
  output logic [tcb_pkg::ADDR_W-1:0] opExecAddr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released lines show the inverse of their last value, except busWrData, which holds its value, so stale data is never mistaken.
  initial
  begin
    {busValid, busAddr, busRead, busRdData, busWrData} = '0;
    {cofValid, cofAddr, cofPaged, opExecValid, opExecAddr} = '0;
  end

  task automatic change_of_flow(input logic [ADDR_W-1:0] a, input logic p);
    @(posedge ref_clk);
    cofValid <= 1'b1;
    cofAddr <= a;
    cofPaged <= p;
    @(posedge ref_clk);
    cofValid <= 1'b0;
    cofAddr <= ~a;
    cofPaged <= ~p;
  endtask

  task automatic bus_cycle(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busValid <= 1'b1;
    busAddr <= a;
    busRead <= 1'b1;
    busRdData <= d;
    busWrData <= ~d;
    opExecValid <= 1'b1;
    opExecAddr <= a;
    @(posedge ref_clk);
    busValid <= 1'b0;
    busAddr <= ~a;
    busRead <= 1'b0;
    busRdData <= ~d;
    opExecValid <= 1'b0;
    opExecAddr <= ~a;
    // Returning off the edge lets the bench read its break tallies without a race.
    @(negedge ref_clk);
  endtask

  // An executed opcode report with no bus access beside it.
  task automatic exec_only(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    opExecValid <= 1'b1;
    opExecAddr <= a;
    @(posedge ref_clk);
    opExecValid <= 1'b0;
    opExecAddr <= ~a;
    @(negedge ref_clk);
  endtask
endmodule

// file: sim/tcb_top_test.sv
// Self-checking bench for the trace compare block with a counting reference model.
module tcb_top_test
  import tcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, arst_n = 1'b0, sysRst = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [REG_AW-1:0] regAddr = '0;
  logic [7:0] regWrData = '0, regRdData, busRdData, busWrData, rdVal;
  logic busValid, busRead, cofValid, cofPaged, opExecValid, forceBreak, tagBreak;
  logic [ADDR_W-1:0] busAddr, cofAddr, opExecAddr, x;
  logic [ADDR_W-1:0] q[$];
  int mismatches = 0, tests_run = 0, forceSeen = 0, tagSeen = 0, expCnt, n, seed = 16019;

  tcb_top dut_u (.ref_clk, .arst_n, .sysRst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .busValid, .busAddr, .busRead, .busRdData, .busWrData, .cofValid,
    .cofAddr, .cofPaged, .opExecValid, .opExecAddr, .forceBreak, .tagBreak);
  tcb_core_model core_u (.ref_clk, .busValid, .busAddr, .busRead, .busRdData,
    .busWrData, .cofValid, .cofAddr, .cofPaged, .opExecValid, .opExecAddr);

  always #5 ref_clk = ~ref_clk;
  // Break outputs are one-cycle pulses, so they are tallied on every rising edge.
  always @(posedge ref_clk)
  begin
    if (forceBreak === 1'b1) forceSeen++;
    if (tagBreak === 1'b1) tagSeen++;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    rdVal = regRdData;
  endtask
  task automatic pulse_rst();
    @(posedge ref_clk);
    sysRst <= 1'b1;
    @(posedge ref_clk);
    sysRst <= 1'b0;
  endtask
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(OFS_COUNT); chk("count", rdVal, 8'h00);
    rd(OFS_TRIG); chk("trig", rdVal, TRIG_RST);
    rd(5'h1F); chk("unmapped", rdVal, 8'h00);
    // End run, A or B, force breaks; random burst length of 3 to 12 lands below, at or above the saturation point.
    wr(OFS_TRIG, 8'h01);
    wr(OFS_CTRL, 8'hD0);
    n = 3 + ($unsigned($random(seed)) % 10);
    // The queue keeps only the newest eight, as an end run overwrites the oldest.
    for (int i = 0; i < n; i++)
    begin
      x = 17'($random(seed));
      q.push_back(x);
      if (q.size() > 8) void'(q.pop_front());
      core_u.change_of_flow(x, 1'b0);
    end
    expCnt = (n > 8) ? 8 : n;
    rd(OFS_COUNT); chk("count", rdVal, 8'(expCnt));
    core_u.bus_cycle('0, 8'(seed));
    chk("force", 8'(forceSeen), 8'h01);
    chk("tag", 8'(tagSeen), 8'h00);
    for (int i = 0; i < expCnt; i++)
    begin
      rd(OFS_FIFO_EXT); chk("fifoExt", rdVal, {7'h00, q[i][16]});
      rd(OFS_FIFO_HIGH); chk("fifoHigh", rdVal, q[i][15:8]);
      rd(OFS_FIFO_LOW); chk("fifoLow", rdVal, q[i][7:0]);
    end
    rd(OFS_COUNT); chk("count", rdVal, 8'(expCnt));
    // Tag-type run, then a run with breaks disabled.
    wr(OFS_CTRL, 8'hF0);
    core_u.bus_cycle('0, 8'h5A);
    chk("tag", 8'(tagSeen), 8'h01);
    rd(OFS_COUNT); chk("count", rdVal, 8'h00);
    wr(OFS_CTRL, 8'hC0);
    core_u.bus_cycle('0, 8'hA5);
    chk("force", 8'(forceSeen + tagSeen), 8'h02);
    // Chip reset ending an end run keeps the tally, a second one clears it.
    wr(OFS_CTRL, 8'hD0);
    repeat (3) core_u.change_of_flow(17'($random(seed)), 1'b1);
    pulse_rst();
    rd(OFS_COUNT); chk("count", rdVal, 8'h03);
    rd(OFS_CTRL); chk("ctrl", rdVal, 8'h80);
    pulse_rst();
    rd(OFS_COUNT); chk("count", rdVal, 8'h00);
    rd(OFS_CTRL); chk("ctrl", rdVal, CTRL_RST);
    // Loop suppression drops repeats of the last stored change of flow.
    wr(OFS_TRIG, 8'h01);
    wr(OFS_CTRL, 8'hC1);
    x = 17'($random(seed)) | 17'h00001;
    core_u.change_of_flow(x, 1'b1);
    core_u.change_of_flow(x, 1'b1);
    core_u.change_of_flow(x ^ 17'h00002, 1'b0);
    core_u.change_of_flow(x ^ 17'h00002, 1'b0);
    core_u.change_of_flow(x, 1'b1);
    rd(OFS_COUNT); chk("count", rdVal, 8'h03);
    rd(5'h07); chk("cmpCExt", rdVal, {1'b1, 6'h00, x[16]});
    rd(5'h09); chk("cmpCLow", rdVal, x[7:0]);
    // Without the module enable nothing is armed, captured or broken.
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h50);
    repeat (2) core_u.change_of_flow(17'($random(seed)), 1'b0);
    core_u.bus_cycle('0, 8'h3C);
    rd(OFS_COUNT); chk("count", rdVal, 8'h03);
    chk("force", 8'(forceSeen + tagSeen), 8'h02);
    // Begin run, A only: the break waits for the eighth capture.
    wr(OFS_TRIG, 8'h40);
    wr(OFS_CTRL, 8'hD0);
    core_u.bus_cycle('0, 8'h11);
    repeat (7) core_u.change_of_flow(17'($random(seed)), 1'b0);
    chk("force", 8'(forceSeen), 8'h01);
    core_u.change_of_flow(17'($random(seed)), 1'b1);
    @(negedge ref_clk);
    chk("force", 8'(forceSeen), 8'h02);
    rd(OFS_COUNT); chk("count", rdVal, 8'h08);
    rd(OFS_CTRL); chk("ctrl", rdVal, 8'h90);
    // Full mode A and B: A address with B on the data bus, direction from A's bits.
    wr(OFS_TRIG, 8'h05);
    wr(5'h06, 8'h3C);
    wr(OFS_RWSEL, 8'h08);
    wr(OFS_CTRL, 8'hD0);
    core_u.bus_cycle('0, 8'h3C);
    chk("force", 8'(forceSeen), 8'h02);
    wr(OFS_RWSEL, 8'h02);
    core_u.bus_cycle('0, 8'h3D);
    chk("force", 8'(forceSeen), 8'h02);
    core_u.bus_cycle('0, 8'h3C);
    chk("force", 8'(forceSeen), 8'h03);
    rd(OFS_STATUS); chk("status", rdVal, 8'hC0);
    // Opcode-qualified tag breakpoint in A or B mode: an executed address matching neither gives none, then one on A.
    wr(OFS_TRIG, 8'h81);
    wr(OFS_CTRL, 8'hF0);
    core_u.exec_only(17'h00001);
    chk("tag", 8'(tagSeen), 8'h01);
    core_u.exec_only('0);
    chk("tag", 8'(tagSeen), 8'h02);
    stop_test();
  end
endmodule
